// ===== core/tv_encoder_power_and_bandwidth_ctrl.sv
// Power state sequencing, output gating, TV sense and filter setup

`timescale 1ns/100ps
`include "tv_pwr_regs.svh"
module tv_encoder_power_and_bandwidth_ctrl (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic pwr_write,
  input wire logic [2:0] pwr_code,
  input wire logic bw_write,
  input wire tv_pwr_pkg::bw_fields_t bw_fields,
  input wire logic [4:0] display_mode,
  input wire logic aux_clock_is_output,
  input wire logic aux_clock_source,
  input wire logic master_clock_mode,
  input wire logic sense_svideo_pin,
  input wire logic sense_composite_pin,
  output logic [2:0] pwr_code_reg,
  output tv_pwr_pkg::bw_fields_t bw_fields_reg,
  output tv_pwr_pkg::pwr_state_t state_reg,
  output tv_pwr_pkg::power_gates_t gates_reg,
  output logic aux_clock_select_reg,
  output logic svideo_present_reg,
  output logic composite_present_reg,
  output tv_pwr_pkg::filter_cfg_t filter_cfg
);

  localparam int SENSE_CHANNELS = `SENSE_CHANNEL_COUNT;

  tv_pwr_pkg::pwr_state_t state_next;
  tv_pwr_pkg::power_gates_t gates_next;
  logic [2:0] code_next;
  tv_pwr_pkg::bw_fields_t bw_next;
  logic bw_load_reg;
  wire logic code_valid;
  wire logic code_accept;
  wire logic aux_next;

  // One named wire per registered state except full down
  wire logic in_normal;
  wire logic in_power_down;
  wire logic in_svideo_off;
  wire logic in_composite_off;

  // Gate enables, decoded from the registered state and the two clock mode inputs
  wire logic running;
  wire logic core_on;
  wire logic svideo_dac_on;
  wire logic composite_dac_on;
  wire logic aux_clock_on;
  wire logic pixel_clock_on;
  wire logic control_port_on;

  // Sense channels, one bit per output connector
  wire logic [SENSE_CHANNELS-1:0] sense_pins;
  wire logic [SENSE_CHANNELS-1:0] sense_synced;

  // Unknown codes are ignored so one valid state always holds
  assign code_valid = pwr_code <= `PWR_CODE_COMPOSITE_OFF;
  // Slave only: nothing but a host write moves the state
  assign code_accept = pwr_write && code_valid;
  assign code_next = code_accept ? pwr_code : pwr_code_reg;
  assign bw_next = bw_write ? bw_fields : bw_fields_reg;
  assign aux_next = aux_clock_source ? `AUX_SEL_REF : `AUX_SEL_VCO;

  always_comb begin
    state_next = state_reg;
    // Refused codes leave state and readback untouched
    if (code_accept) begin
      case (pwr_code)
        `PWR_CODE_NORMAL: state_next = tv_pwr_pkg::st_normal;
        `PWR_CODE_POWER_DOWN: state_next = tv_pwr_pkg::st_power_down;
        `PWR_CODE_FULL_DOWN: state_next = tv_pwr_pkg::st_full_down;
        `PWR_CODE_SVIDEO_OFF: state_next = tv_pwr_pkg::st_svideo_off;
        `PWR_CODE_COMPOSITE_OFF: state_next = tv_pwr_pkg::st_composite_off;
        default: state_next = state_reg;
      endcase
    end
  end

  assign in_normal = state_reg == tv_pwr_pkg::st_normal;
  assign in_power_down = state_reg == tv_pwr_pkg::st_power_down;
  assign in_svideo_off = state_reg == tv_pwr_pkg::st_svideo_off;
  assign in_composite_off = state_reg == tv_pwr_pkg::st_composite_off;

  // Full down is where running and power down are both low
  assign running = in_normal || in_svideo_off || in_composite_off;
  assign core_on = running;
  assign svideo_dac_on = running && !in_svideo_off;
  assign composite_dac_on = running && !in_composite_off;
  assign aux_clock_on = running || (in_power_down && aux_clock_is_output);
  assign pixel_clock_on = running || (in_power_down && master_clock_mode);
  // Port must stay up or the host could never wake the part
  assign control_port_on = `GATE_ON;

  // Gates lag the state by one cycle, the price of registered outputs
  always_comb begin
    gates_next.core_enable = core_on;
    gates_next.svideo_dac_enable = svideo_dac_on;
    gates_next.composite_dac_enable = composite_dac_on;
    gates_next.aux_clock_enable = aux_clock_on;
    gates_next.pixel_clock_enable = pixel_clock_on;
    gates_next.control_port_enable = control_port_on;
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state_reg <= tv_pwr_pkg::st_normal;
    end else begin
      state_reg <= state_next;
    end
  end

  // Readback shows the last accepted code only
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      pwr_code_reg <= `PWR_CODE_NORMAL;
    end else begin
      pwr_code_reg <= code_next;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      gates_reg <= `GATES_OFF;
    end else begin
      gates_reg <= gates_next;
    end
  end

  // Raw fields kept for readback, low S-Video bit included
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      bw_fields_reg <= `BW_RESET;
    end else begin
      bw_fields_reg <= bw_next;
    end
  end

  // Reload each cycle so a display mode change is tracked too
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      bw_load_reg <= `LOAD_ON;
    end else begin
      bw_load_reg <= `LOAD_ON;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      aux_clock_select_reg <= `AUX_SEL_VCO;
    end else begin
      aux_clock_select_reg <= aux_next;
    end
  end

  assign sense_pins[`SENSE_CH_SVIDEO] = sense_svideo_pin;
  assign sense_pins[`SENSE_CH_COMPOSITE] = sense_composite_pin;

  // Sense pins are asynchronous: two stages before any logic reads them
  genvar ch;
  generate
    for (ch = 0; ch < SENSE_CHANNELS; ch++) begin : g_sense_sync
      logic first_reg;
      logic second_reg;
      always_ff @(posedge clock) begin
        if (sys_rst) begin
          first_reg <= `SENSE_CLEAR;
          second_reg <= `SENSE_CLEAR;
        end else begin
          first_reg <= sense_pins[ch];
          second_reg <= first_reg;
        end
      end
      // Only the second stage leaves the loop
      assign sense_synced[ch] = second_reg;
    end
  endgenerate

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      svideo_present_reg <= `SENSE_CLEAR;
    end else begin
      svideo_present_reg <= sense_synced[`SENSE_CH_SVIDEO];
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      composite_present_reg <= `SENSE_CLEAR;
    end else begin
      composite_present_reg <= sense_synced[`SENSE_CH_COMPOSITE];
    end
  end

  tv_filter_select u_filter (
    .clock(clock),
    .sys_rst(sys_rst),
    .load(bw_load_reg),
    .display_mode(display_mode),
    .fields(bw_fields_reg),
    .cfg_reg(filter_cfg)
  );
endmodule : tv_encoder_power_and_bandwidth_ctrl

// ===== core/tv_pwr_regs.svh
// Constants for the power and bandwidth control block
`ifndef TV_PWR_REGS_SVH
`define TV_PWR_REGS_SVH
`define PWR_CODE_NORMAL 3'h0
`define PWR_CODE_POWER_DOWN 3'h1
`define PWR_CODE_FULL_DOWN 3'h2
`define PWR_CODE_SVIDEO_OFF 3'h3
`define PWR_CODE_COMPOSITE_OFF 3'h4
`define MODE_MAX 5'h1A
`define AUX_SEL_VCO 1'h0
`define AUX_SEL_REF 1'h1
`define SVIDEO_BW_WIDE_BIT 1
`define SVIDEO_BW_WIDEST 2'h2
`define BW_RESET 6'h00
`define MODE_RESET 5'h00
`define GATE_ON 1'h1
`define GATES_OFF 6'h00
`define SENSE_CLEAR 1'h0
`define LOAD_ON 1'h1
`define SENSE_CHANNEL_COUNT 2
`define SENSE_CH_SVIDEO 0
`define SENSE_CH_COMPOSITE 1
`endif

// ===== core/tv_pwr_pkg.sv
// Types for the power and bandwidth control block
package tv_pwr_pkg;
  typedef enum logic [2:0] {
    st_normal, st_power_down, st_full_down, st_svideo_off, st_composite_off
  } pwr_state_t;
  typedef struct packed {
    logic [1:0] chroma_bw_select;
    logic composite_luma_bw_select;
    logic [1:0] svideo_luma_bw_select;
    logic svideo_luma_peaking_enable;
  } bw_fields_t;
  typedef struct packed {
    logic [4:0] display_mode;
    logic [1:0] chroma_bw;
    logic composite_luma_bw;
    logic [1:0] svideo_luma_bw;
    logic svideo_peaking;
  } filter_cfg_t;
  typedef struct packed {
    logic core_enable;
    logic svideo_dac_enable;
    logic composite_dac_enable;
    logic aux_clock_enable;
    logic pixel_clock_enable;
    logic control_port_enable;
  } power_gates_t;
endpackage : tv_pwr_pkg

// ===== core/tv_filter_select.sv
// Filter bandwidth selection from display mode and programmed fields
`timescale 1ns/100ps
`include "tv_pwr_regs.svh"
module tv_filter_select (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic load,
  input wire logic [4:0] display_mode,
  input wire tv_pwr_pkg::bw_fields_t fields,
  output tv_pwr_pkg::filter_cfg_t cfg_reg
);
  tv_pwr_pkg::filter_cfg_t cfg_next;
  wire logic mode_ok;
  wire logic [1:0] svideo_code;
  assign mode_ok = display_mode <= `MODE_MAX;
  // Codes 10 and 11 both select the widest response
  assign svideo_code = fields.svideo_luma_bw_select[`SVIDEO_BW_WIDE_BIT] ?
    `SVIDEO_BW_WIDEST : fields.svideo_luma_bw_select;
  always_comb begin
    cfg_next = cfg_reg;
    // Out of range modes keep the previous setting
    if (load && mode_ok) begin
      cfg_next.display_mode = display_mode;
      cfg_next.chroma_bw = fields.chroma_bw_select;
      cfg_next.composite_luma_bw = fields.composite_luma_bw_select;
      cfg_next.svideo_luma_bw = svideo_code;
      cfg_next.svideo_peaking = fields.svideo_luma_peaking_enable;
    end
  end
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      cfg_reg <= '0;
    end else begin
      cfg_reg <= cfg_next;
    end
  end
endmodule : tv_filter_select

// ===== test/tv_pwr_props.sv
// Checker for the power state and bandwidth control ports
`timescale 1ns/100ps
module tv_pwr_props (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic pwr_write,
  input wire logic [2:0] pwr_code,
  input wire logic [4:0] display_mode,
  input wire logic aux_clock_is_output,
  input wire logic master_clock_mode,
  input wire logic sense_svideo_pin,
  input wire logic [2:0] pwr_code_reg,
  input wire tv_pwr_pkg::pwr_state_t state_reg,
  input wire tv_pwr_pkg::power_gates_t gates_reg,
  input wire logic svideo_present_reg,
  input wire tv_pwr_pkg::filter_cfg_t filter_cfg
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  sequence s_accept; pwr_write && pwr_code <= 3'h4; endsequence
  sequence s_refuse; pwr_write && pwr_code > 3'h4; endsequence
  property p_take; s_accept |=> pwr_code_reg == $past(pwr_code); endproperty
  property p_refuse; s_refuse |=> $stable(pwr_code_reg); endproperty
  property p_normal; state_reg == tv_pwr_pkg::st_normal |=> gates_reg == 6'h3F; endproperty
  property p_pd; state_reg == tv_pwr_pkg::st_power_down |=>
    gates_reg == {3'h0, $past(aux_clock_is_output), $past(master_clock_mode), 1'h1};
  endproperty
  property p_full; state_reg == tv_pwr_pkg::st_full_down |=> gates_reg == 6'h01; endproperty
  property p_svoff; state_reg == tv_pwr_pkg::st_svideo_off |=> gates_reg == 6'h2F; endproperty
  property p_cvoff; state_reg == tv_pwr_pkg::st_composite_off |=> gates_reg == 6'h37; endproperty
  property p_sense; sense_svideo_pin [*4] |-> svideo_present_reg; endproperty
  property p_widest; filter_cfg.svideo_luma_bw != 2'h3; endproperty
  property p_mode; display_mode <= 5'h1A |=> filter_cfg.display_mode == $past(display_mode);
  endproperty
  a_take: assert property (p_take) else $error("state code not taken");
  a_refuse: assert property (p_refuse) else $error("bad code accepted");
  a_normal: assert property (p_normal) else $error("normal gates wrong");
  a_pd: assert property (p_pd) else $error("power down gates wrong");
  a_full: assert property (p_full) else $error("full down gates wrong");
  a_svoff: assert property (p_svoff) else $error("svideo off gates wrong");
  a_cvoff: assert property (p_cvoff) else $error("composite off gates wrong");
  a_sense: assert property (p_sense) else $error("sense missed");
  a_widest: assert property (p_widest) else $error("svideo code 11 shown");
  a_mode: assert property (p_mode) else $error("mode not applied");
endmodule : tv_pwr_props
bind tv_encoder_power_and_bandwidth_ctrl tv_pwr_props u_tv_pwr_props (.clock, .sys_rst,
  .pwr_write, .pwr_code, .display_mode, .aux_clock_is_output, .master_clock_mode,
  .sense_svideo_pin, .pwr_code_reg, .state_reg, .gates_reg, .svideo_present_reg, .filter_cfg);

// ===== test/tv_load_model.sv
// Model of a TV load seen on the sense pins
`timescale 1ns/100ps
module tv_load_model (
  input wire logic svideo_attached,
  input wire logic composite_attached,
  output logic sense_svideo_pin,
  output logic sense_composite_pin
);
  assign sense_svideo_pin = svideo_attached;
  assign sense_composite_pin = composite_attached;
endmodule : tv_load_model

// ===== test/tv_encoder_power_and_bandwidth_ctrl_tb_top.sv
// Self-checking bench for the power and bandwidth control block
`timescale 1ns/100ps
module tv_encoder_power_and_bandwidth_ctrl_tb_top;
  logic clock = 1'h0, sys_rst = 1'h1, pwr_write = 1'h0, bw_write = 1'h0, src = 1'h0;
  logic aux_io = 1'h0, mst = 1'h0, att_sv = 1'h0, att_cv = 1'h0, aux_sel, sv_p, cv_p;
  logic sns_sv, sns_cv;
  logic [2:0] pwr_code = 3'h0, exp_code = 3'h0, pwr_code_reg;
  logic [4:0] disp = 5'h00;
  logic [10:0] exp_cfg = 11'h000;
  tv_pwr_pkg::bw_fields_t bw_fields = 6'h00, exp_bw = 6'h00, bw_fields_reg;
  tv_pwr_pkg::pwr_state_t state_reg;
  tv_pwr_pkg::power_gates_t gates_reg;
  tv_pwr_pkg::filter_cfg_t filter_cfg;
  int err_count = 0, samples_checked = 0, cycles = 0;
  tv_load_model u_tv_load_model (.svideo_attached(att_sv), .composite_attached(att_cv),
    .sense_svideo_pin(sns_sv), .sense_composite_pin(sns_cv));
  tv_encoder_power_and_bandwidth_ctrl u_tv_encoder_power_and_bandwidth_ctrl (.clock, .sys_rst,
    .pwr_write, .pwr_code, .bw_write, .bw_fields, .display_mode(disp),
    .aux_clock_is_output(aux_io), .aux_clock_source(src), .master_clock_mode(mst),
    .sense_svideo_pin(sns_sv), .sense_composite_pin(sns_cv), .pwr_code_reg, .bw_fields_reg,
    .state_reg, .gates_reg, .aux_clock_select_reg(aux_sel), .svideo_present_reg(sv_p),
    .composite_present_reg(cv_p), .filter_cfg);
  always #50 clock = ~clock;
  always @(posedge clock) begin
    cycles++;
    if (cycles > 3000) begin
      err_count++;
      tally_and_finish();
    end
  end
  function automatic logic [5:0] gates_of(logic [2:0] c, logic a, logic m);
    case (c)
      3'h0: return 6'h3F;
      3'h1: return {3'h0, a, m, 1'h1};
      3'h2: return 6'h01;
      3'h3: return 6'h2F;
      default: return 6'h37;
    endcase
  endfunction : gates_of
  // Low svideo bit is dropped once the wide bit is set
  function automatic logic [10:0] cfg_of(logic [4:0] m, logic [5:0] f);
    return {m, f[5:3], f[2] ? 2'h2 : f[2:1], f[0]};
  endfunction : cfg_of
  task chk(input logic [10:0] seen, input logic [10:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : chk
  // Entered 10 ns after an edge; gates lag state by one edge
  task cyc(input logic pw, input logic [2:0] c, input logic bw, input logic [5:0] f);
    logic [5:0] g;
    pwr_write = pw;
    pwr_code = c;
    bw_write = bw;
    bw_fields = f;
    g = gates_of(exp_code, aux_io, mst);
    // Filter takes the fields already held; bad modes freeze it
    if (disp <= 5'h1A) exp_cfg = cfg_of(disp, exp_bw);
    @(posedge clock);
    #5;
    if (pw && c <= 3'h4) exp_code = c;
    if (bw) exp_bw = f;
    chk(11'(pwr_code_reg), 11'(exp_code));
    chk(11'(state_reg), 11'(exp_code));
    chk(11'(bw_fields_reg), 11'(exp_bw));
    chk(11'(gates_reg), 11'(g));
    chk(11'(aux_sel), 11'(src));
    chk(11'(filter_cfg), exp_cfg);
    #5;
  endtask : cyc
  task tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : tally_and_finish
  initial begin
    void'($urandom(54224));
    repeat (2) @(posedge clock);
    #10 sys_rst = 1'h0;
    for (int i = 0; i < 8; i++) begin
      cyc(1'h1, 3'(i), 1'h0, 6'h00);
      cyc(1'h0, 3'h0, 1'h0, 6'h00);
    end
    $display("test state codes done");
    disp = 5'h05;
    cyc(1'h0, 3'h0, 1'h1, 6'h3F);
    cyc(1'h0, 3'h0, 1'h0, 6'h00);
    chk(filter_cfg, cfg_of(5'h05, 6'h3F));
    disp = 5'h1F;
    cyc(1'h0, 3'h0, 1'h0, 6'h00);
    chk(filter_cfg, cfg_of(5'h05, 6'h3F));
    $display("test filter done");
    att_cv = 1'h1;
    repeat (4) cyc(1'h0, 3'h0, 1'h0, 6'h00);
    chk(11'({sv_p, cv_p}), 11'h001);
    cyc(1'h1, (cv_p && !sv_p) ? 3'h3 : 3'h0, 1'h0, 6'h00);
    cyc(1'h0, 3'h0, 1'h0, 6'h00);
    $display("test sense done");
    repeat (500) begin
      aux_io = 1'($urandom);
      mst = 1'($urandom);
      src = 1'($urandom);
      att_sv = 1'($urandom % 8 == 0);
      disp = 5'($urandom);
      cyc($urandom % 3 == 0, 3'($urandom), $urandom % 4 == 0, 6'($urandom));
    end
    $display("test random done");
    tally_and_finish();
  end
endmodule : tv_encoder_power_and_bandwidth_ctrl_tb_top
